/* adc_powerdown_reset_control.sv */
`timescale 1ns/1ps
// ==========================================================
// power-down / reset / power-on start-up controller
module adc_powerdown_reset_control
    import aprc_pkg::*;
#(
    parameter int IFACE_CNT = aprc_pkg::IFACE_CYCLES,
    parameter int REF_CNT = aprc_pkg::REF_CYCLES
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic POWERDOWN_RESET_N_IN,
    input wire logic CFG_WR_IN,
    input wire logic [aprc_pkg::CFG_WIDTH-1:0] CFG_DATA_IN,
    input wire logic CONV_REQ_IN,
    output logic [aprc_pkg::CFG_WIDTH-1:0] CFG_OUT,
    output logic POWERED_OUT,
    output logic IFACE_READY_OUT,
    output logic CONV_READY_OUT,
    output logic CONFIGURED_OUT,
    output logic AVG_ENABLE_OUT,
    output logic CONV_START_OUT
);
    import aprc_pkg::*;

    logic pin_s1_reg;
    logic pin_s2_reg;
    logic rst_pulse;
    logic pd_pulse;
    aprc_mode_e mode_reg;
    logic [CNT_WIDTH-1:0] up_cnt_reg;

    // ==========================================================
    // pin synchroniser: pin is async to everything else
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
        end else begin
            pin_s1_reg <= POWERDOWN_RESET_N_IN;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    aprc_low_timer #(
        .THRESH(PD_CYCLES)
    ) u_timer (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .pin_n_in(pin_s2_reg),
        .reset_pulse_out(rst_pulse),
        .pd_pulse_out(pd_pulse)
    );

    // ==========================================================
    // mode: power-on reset starts the up counter like a release
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mode_reg <= APRC_STARTUP;
        end else if (pd_pulse) begin
            mode_reg <= APRC_POWERDOWN;
        end else begin
            case (mode_reg)
                APRC_POWERDOWN: if (pin_s2_reg) mode_reg <= APRC_STARTUP;
                APRC_STARTUP: if (up_cnt_reg >= CNT_WIDTH'(IFACE_CNT)) mode_reg <= APRC_NORMAL;
                APRC_NORMAL: mode_reg <= APRC_NORMAL;
                default: mode_reg <= APRC_STARTUP;
            endcase
        end
    end

    // ==========================================================
    // power-up timer; restarts on each power-down exit, saturates
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            up_cnt_reg <= '0;
        end else if (mode_reg == APRC_POWERDOWN) begin
            up_cnt_reg <= '0;
        end else if (up_cnt_reg < CNT_WIDTH'(REF_CNT)) begin
            up_cnt_reg <= up_cnt_reg + 1'b1;
        end
    end
    // ==========================================================
    // configuration register; cleared on reset, power-down, por
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            CFG_OUT <= CFG_RESET;
            CONFIGURED_OUT <= 1'b0;
            AVG_ENABLE_OUT <= 1'b0;
        end else if (rst_pulse || pd_pulse || mode_reg == APRC_POWERDOWN || !pin_s2_reg) begin
            CFG_OUT <= CFG_RESET;
            CONFIGURED_OUT <= 1'b0;
            AVG_ENABLE_OUT <= 1'b0;
        end else if (CFG_WR_IN && mode_reg == APRC_NORMAL) begin
            CFG_OUT <= CFG_DATA_IN; // writes before ready are dropped
            CONFIGURED_OUT <= 1'b1;
            AVG_ENABLE_OUT <= 1'b1;
        end
    end

    // ==========================================================
    // status and conversion start; internal ref needs long wait
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            POWERED_OUT <= 1'b0;
            IFACE_READY_OUT <= 1'b0;
            CONV_READY_OUT <= 1'b0;
            CONV_START_OUT <= 1'b0;
        end else begin
            POWERED_OUT <= mode_reg != APRC_POWERDOWN && !pd_pulse;
            IFACE_READY_OUT <= mode_reg == APRC_NORMAL && !pd_pulse && pin_s2_reg;
            CONV_READY_OUT <= mode_reg == APRC_NORMAL && CONFIGURED_OUT && pin_s2_reg && !pd_pulse &&
                (CFG_OUT[CFG_EXT_REF_BIT] || up_cnt_reg >= CNT_WIDTH'(REF_CNT));
            CONV_START_OUT <= CONV_REQ_IN && CONV_READY_OUT && pin_s2_reg && !pd_pulse;
        end
    end

    // ==========================================================
    // checks
    a_pd_enter: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        pd_pulse |=> mode_reg == APRC_POWERDOWN) else $error("power-down not entered");
    a_pd_quiet: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        mode_reg == APRC_POWERDOWN |=> !CONV_START_OUT && CFG_OUT == CFG_RESET) else $error("active in power-down");
    // three-cycle low, well below the power-down threshold
    sequence s_short_low;
        $fell(pin_s2_reg) ##1 (!pin_s2_reg)[*2] ##1 pin_s2_reg;
    endsequence
    // nine synchronised low cycles: the power-down threshold
    sequence s_long_low;
        $fell(pin_s2_reg) ##1 (!pin_s2_reg)[*8];
    endsequence
    a_long_pd: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_long_low |-> ##2 mode_reg == APRC_POWERDOWN) else $error("long low missed power-down");
    a_pd_dark: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        mode_reg == APRC_POWERDOWN |=> !POWERED_OUT && !AVG_ENABLE_OUT) else $error("powered in power-down");
    a_ready_norm: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        IFACE_READY_OUT |-> $past(mode_reg) == APRC_NORMAL) else $error("ready outside normal");
    a_short_reset: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_short_low |-> ##1 mode_reg != APRC_POWERDOWN) else $error("short pulse powered down");
    a_cfg_clear: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        rst_pulse |=> CFG_OUT == CFG_RESET && !AVG_ENABLE_OUT) else $error("config not cleared");
    a_wr_ready: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $changed(CFG_OUT) && CFG_OUT != CFG_RESET |-> $past(mode_reg) == APRC_NORMAL) else $error("early write");
    a_ref_wait: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        CONV_READY_OUT && !$past(CFG_OUT[CFG_EXT_REF_BIT]) |-> $past(up_cnt_reg) >= CNT_WIDTH'(REF_CNT))
        else $error("ref wait");
    a_release_up: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        mode_reg == APRC_POWERDOWN && pin_s2_reg && !pd_pulse |=> mode_reg == APRC_STARTUP) else $error("no restart");
    a_conv_cfg: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        CONV_START_OUT |-> $past(CONFIGURED_OUT, 2)) else $error("conversion before config");
endmodule // adc_powerdown_reset_control

/* aprc_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// host side of the dual-function pin
module aprc_host_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [7:0] low_cyc_in,
    output logic pin_n_out
);
    logic [7:0] cnt_reg = 8'h00;
    // low time in cycles; bench never asks for 6 to 9
    always @(posedge clk_in) begin
        if (go_in) begin
            cnt_reg <= low_cyc_in;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
    // skewed off the edge, the pin has no clock relation
    assign #3 pin_n_out = (cnt_reg == 8'h00);
endmodule // aprc_host_model

/* aprc_low_timer.sv */
`timescale 1ns/1ps
// ==========================================================
// low time measure of the dual-function pin
module aprc_low_timer #(
    parameter int THRESH = 9
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pin_n_in,
    output logic reset_pulse_out,
    output logic pd_pulse_out
);
    logic [7:0] cnt_reg;
    logic pin_d_reg;
    logic pd_done_reg;

    // saturating count while low; power-down at threshold, reset pulse on the fall
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= 8'h00;
            pin_d_reg <= 1'b1;
            pd_done_reg <= 1'b0;
            reset_pulse_out <= 1'b0;
            pd_pulse_out <= 1'b0;
        end else begin
            pin_d_reg <= pin_n_in;
            reset_pulse_out <= !pin_n_in && pin_d_reg; // reset on every falling edge
            pd_pulse_out <= 1'b0;
            if (pin_n_in) begin
                cnt_reg <= 8'h00;
                pd_done_reg <= 1'b0;
            end else begin
                if (cnt_reg != 8'hFF)
                    cnt_reg <= cnt_reg + 8'h01;
                if (cnt_reg == 8'(THRESH - 1) && !pd_done_reg) begin
                    pd_pulse_out <= 1'b1;
                    pd_done_reg <= 1'b1;
                end
            end
        end
    end
endmodule // aprc_low_timer

/* aprc_pkg.sv */
// Operation
// - low over 90 ns enters power-down
// - pin accepted anytime, asynchronous to serial
// - power-down ignores all other digital inputs
// - release restarts default; host waits power-up
// - low under 60 ns resets only
// - reset clears config and temperature averaging
// - after reset normal mode; host configures
// - 60 to 90 ns resets, power-down undefined
// - power-on clears config to zeros
// - interface operational 500 us after power-up
// - power-down switches everything off, config default
package aprc_pkg;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_PS = 10000;
    localparam int PD_THRESH_PS = 90000;
    localparam int RST_MAX_PS = 60000;
    localparam int IFACE_READY_US = 500;
    localparam int REF_READY_US = 5500;
    localparam int PD_CYCLES = PD_THRESH_PS / CLK_PERIOD_PS;
    // divide first: the product would overflow a 32-bit int
    localparam int IFACE_CYCLES = IFACE_READY_US * (1000000 / CLK_PERIOD_PS);
    localparam int REF_CYCLES = REF_READY_US * (1000000 / CLK_PERIOD_PS);
    // ==========================================================
    // configuration register
    localparam int CFG_WIDTH = 16;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int CFG_EXT_REF_BIT = 0;
    localparam int CNT_WIDTH = 20;
    typedef enum logic [1:0] {APRC_NORMAL, APRC_POWERDOWN, APRC_STARTUP} aprc_mode_e;
endpackage

/* tb.sv */
`timescale 1ns/1ps
// ==========================================================
// bench
module tb;
    import aprc_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, go = 0, smp = 0, req = 0, pin_n, pwr, rdy, avg, conf, crdy, st;
    logic [15:0] din = 16'h0000, cfg, d;
    logic [7:0] low = 8'h00, lf = 8'h5C;
    logic [21:0] exp_q[$];
    int fails = 0, check_count = 0;
    adc_powerdown_reset_control #(.IFACE_CNT(20), .REF_CNT(50)) i_dut (.CLK_IN(clk), .RST_N_IN(rst_n),
        .POWERDOWN_RESET_N_IN(pin_n), .CFG_WR_IN(wr), .CFG_DATA_IN(din), .CONV_REQ_IN(req), .CFG_OUT(cfg),
        .POWERED_OUT(pwr), .IFACE_READY_OUT(rdy), .CONV_READY_OUT(crdy), .CONFIGURED_OUT(conf),
        .AVG_ENABLE_OUT(avg), .CONV_START_OUT(st));
    aprc_host_model i_host (.clk_in(clk), .go_in(go), .low_cyc_in(low), .pin_n_out(pin_n));
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [21:0] seen, input logic [21:0] e);
        check_count++;
        if (seen !== e) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // note {powered, ready, averaging, configured, conv ready, start} and config
    task automatic note(input logic [5:0] f, input logic [15:0] c);
        exp_q.push_back({f, c});
        smp <= 1'b1;
        @(posedge clk);
        smp <= 1'b0;
        cyc(1);
    endtask
    task automatic write(input logic [15:0] v);
        din <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        cyc(2);
    endtask
    task automatic wait_ready;
        int i;
        for (i = 0; i < 100 && rdy !== 1'b1; i++) @(posedge clk);
        if (rdy !== 1'b1) begin
            fails++;
            stop_test();
        end
    endtask
    // one request cycle; the start pulse stands at the next sample
    task automatic conv;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
    endtask
    task automatic pulse(input logic [7:0] n);
        low <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // watcher pairs each sample with the oldest note
    always @(posedge clk) begin
        if (smp) check({pwr, rdy, avg, conf, crdy, st, cfg}, exp_q.pop_front());
    end
    // main sequence
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(2);
        lf = nxt(lf);
        d = {lf, ~lf};
        write(d); // host writes early only to see it refused
        note(6'b100000, 16'h0000);
        wait_ready(); // host keeps the start-up wait
        write(d);
        note(6'b111110, d);
        conv();
        note(6'b111111, d);
        $display("startup done");
        pulse(8'h03);
        cyc(8);
        note(6'b110000, 16'h0000);
        conv();
        note(6'b110000, 16'h0000);
        lf = nxt(lf);
        d = {~lf, lf} | 16'h0001;
        write(d);
        note(6'b111110, d);
        $display("short pulse done");
        pulse(8'h1E);
        cyc(16);
        write(d);
        conv();
        note(6'b000000, 16'h0000);
        cyc(14);
        note(6'b100000, 16'h0000);
        wait_ready();
        write(16'h00F1);
        note(6'b111110, 16'h00F1);
        write(16'h00F0);
        note(6'b111100, 16'h00F0);
        cyc(30);
        conv();
        note(6'b111111, 16'h00F0);
        $display("power-down done");
        stop_test();
    end
endmodule // tb
